// ==== hdl/fcd_consts.svh ====
// constants of the flash command controller
`ifndef FCD_CONSTS_SVH
`define FCD_CONSTS_SVH
`define FCD_CLK_NS 4
`define FCD_CYC_UP(ns) (((ns) + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`define FCD_CYC_DN(ns) ((ns) / `FCD_CLK_NS)
`define FCD_SETUP_NS 10
`define FCD_WE_PULSE_NS 35
`define FCD_ACCESS_NS 70
`define FCD_HOLD_NS 20
`define FCD_SYNC_STAGES 2
`define FCD_WINDOW_US 50
`define FCD_SUSP_US 20
`define FCD_REG_CTRL 8'h00
`define FCD_REG_ADDR 8'h04
`define FCD_REG_WDATA 8'h08
`define FCD_REG_STATUS 8'h0C
`define FCD_REG_RDATA 8'h10
`define FCD_ST_BUSY 0
`define FCD_ST_DONE 1
`define FCD_ST_REFUSED 2
`define FCD_ST_READY 3
`define FCD_ST_TIMEOUT 4
`define FCD_ST_BYPASS 5
`define FCD_ST_IDENT 6
`define FCD_ST_SUSP 7
`define FCD_ST_SECT 8
`define FCD_ST_SECURE 9
`define FCD_ST_FAIL 10
`define FCD_DQ_TOGGLE1 6
`define FCD_DQ_TIMEOUT 5
`define FCD_ADR_UNLOCK1 11'h555
`define FCD_ADR_UNLOCK2 11'h2AA
`define FCD_ADR_QUERY 11'h055
`define FCD_CMD_RESET 8'hF0
`define FCD_CMD_UNLOCK1 8'hAA
`define FCD_CMD_UNLOCK2 8'h55
`define FCD_CMD_IDENT 8'h90
`define FCD_CMD_PROG 8'hA0
`define FCD_CMD_BYPASS 8'h20
`define FCD_CMD_ERASE 8'h80
`define FCD_CMD_CHIP 8'h10
`define FCD_CMD_SECTOR 8'h30
`define FCD_CMD_SUSPEND 8'hB0
`define FCD_CMD_QUERY 8'h98
`define FCD_CMD_SECURE 8'h88
`define FCD_CMD_EXIT 8'h00
`endif

// ==== hdl/fcd_cyc_if.sv ====
// one flash bus cycle request between sequencer and cycle engine
`timescale 1ns/1ps
`default_nettype none
interface fcd_cyc_if;
	logic req;
	logic wr;
	logic [19:0] addr;
	logic [15:0] wdata;
	logic done;
	logic [15:0] rdata;
	modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
	modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ==== hdl/fcd_cycle.sv ====
// flash pin cycle engine: one write or read cycle per request
`timescale 1ns/1ps
`default_nettype none
`include "fcd_consts.svh"
module fcd_cycle #(
	parameter int unsigned SETUP_CYC = `FCD_CYC_UP(`FCD_SETUP_NS),
	parameter int unsigned PULSE_CYC = `FCD_CYC_UP(`FCD_WE_PULSE_NS),
	parameter int unsigned ACCESS_CYC = `FCD_CYC_UP(`FCD_ACCESS_NS) + `FCD_SYNC_STAGES,
	parameter int unsigned HOLD_CYC = `FCD_CYC_UP(`FCD_HOLD_NS)
) (
	input wire logic clock,
	input wire logic srst,
	fcd_cyc_if.eng cyc,
	input wire logic [15:0] dq_sync,
	output logic [19:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n
);
	fcd_pkg::fcd_eng_s r_reg, r_next;
	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		if (r_reg.cnt != 8'h00) begin
			r_next.cnt = r_reg.cnt - 8'h01;
		end
		unique case (r_reg.ph)
			fcd_pkg::PH_IDLE: if (cyc.req) begin
				// address and data stand before the strobe falls and after it rises
				r_next.wr = cyc.wr; // R11
				r_next.addr = cyc.addr;
				r_next.dq_out = cyc.wdata;
				r_next.dq_oe = cyc.wr;
				r_next.ce_n = 1'b0;
				r_next.cnt = 8'(SETUP_CYC - 1);
				r_next.ph = fcd_pkg::PH_SETUP;
			end
			fcd_pkg::PH_SETUP: if (r_reg.cnt == 8'h00) begin
				r_next.we_n = !r_reg.wr;
				r_next.oe_n = r_reg.wr;
				// read pulse covers access time plus synchroniser delay
				r_next.cnt = r_reg.wr ? 8'(PULSE_CYC - 1) : 8'(ACCESS_CYC - 1);
				r_next.ph = fcd_pkg::PH_ACT;
			end
			fcd_pkg::PH_ACT: if (r_reg.cnt == 8'h00) begin
				if (!r_reg.wr) begin
					r_next.rdata = dq_sync;
				end
				r_next.we_n = 1'b1; // R11
				r_next.oe_n = 1'b1;
				r_next.cnt = 8'(HOLD_CYC - 1);
				r_next.ph = fcd_pkg::PH_HOLD;
			end
			fcd_pkg::PH_HOLD: if (r_reg.cnt == 8'h00) begin
				r_next.ce_n = 1'b1;
				r_next.dq_oe = 1'b0;
				r_next.done = 1'b1;
				r_next.ph = fcd_pkg::PH_IDLE;
			end
		endcase
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			r_reg <= '0;
			r_reg.ce_n <= 1'b1;
			r_reg.we_n <= 1'b1;
			r_reg.oe_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end
	assign cyc.done = r_reg.done;
	assign cyc.rdata = r_reg.rdata;
	assign flash_addr = r_reg.addr;
	assign flash_dq_out = r_reg.dq_out;
	assign flash_dq_oe = r_reg.dq_oe;
	assign flash_ce_n = r_reg.ce_n;
	assign flash_we_n = r_reg.we_n;
	assign flash_oe_n = r_reg.oe_n;

	// assertion helper: a count keeps the strobe check short for any pulse parameter
	logic [7:0] we_low_cnt;
	always_ff @(posedge clock) begin
		if (srst || flash_we_n) begin
			we_low_cnt <= 8'h00;
		end else begin
			we_low_cnt <= we_low_cnt + 8'h01;
		end
	end
	a_we_pulse_width: assert property (@(posedge clock) disable iff (srst) // R11
		$rose(flash_we_n) |-> we_low_cnt == 8'(PULSE_CYC))
		else $error("write strobe width wrong");
	a_we_under_ce: assert property (@(posedge clock) disable iff (srst) // R11
		!flash_we_n |-> !flash_ce_n && flash_dq_oe && $stable(flash_dq_out))
		else $error("write strobe outside select or data");
endmodule // fcd_cycle
`default_nettype wire

// ==== hdl/fcd_pkg.sv ====
// types of the flash command controller
package fcd_pkg;
	typedef enum logic [3:0] {
		OP_RESET = 4'b0000, OP_READ = 4'b0001, OP_IDENT = 4'b0010, OP_PROG = 4'b0011,
		OP_BYP_EN = 4'b0100, OP_BYP_PROG = 4'b0101, OP_BYP_EXIT = 4'b0110,
		OP_CHIP = 4'b0111, OP_SECT = 4'b1000, OP_SECT_ADD = 4'b1001,
		OP_SUSPEND = 4'b1010, OP_RESUME = 4'b1011, OP_QUERY = 4'b1100,
		OP_SEC_EN = 4'b1101, OP_SEC_EX = 4'b1110, OP_POLL = 4'b1111
	} fcd_op_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_ISSUE = 2'b01, ST_WAIT = 2'b10, ST_SUSP = 2'b11
	} fcd_st_e;
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00, PH_SETUP = 2'b01, PH_ACT = 2'b10, PH_HOLD = 2'b11
	} fcd_ph_e;
	typedef struct packed {
		fcd_ph_e ph;
		logic [7:0] cnt;
		logic wr;
		logic [19:0] addr;
		logic [15:0] dq_out;
		logic dq_oe;
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic done;
		logic [15:0] rdata;
	} fcd_eng_s;
	typedef struct packed {
		fcd_st_e st;
		fcd_op_e op;
		logic [2:0] step;
		logic phase;
		logic [15:0] prev;
		logic [19:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic busy;
		logic done;
		logic refused;
		logic tmo_seen;
		logic poll_fail;
		logic byp;
		logic ident;
		logic susp;
		logic sect;
		logic secure;
		logic [15:0] win_cnt;
		logic [15:0] wait_cnt;
		logic req;
		logic req_wr;
		logic [19:0] req_addr;
		logic [15:0] req_data;
		logic ack;
		logic [31:0] dat;
	} fcd_main_s;
endpackage

// ==== hdl/fcd_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module fcd_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} fcd_sync_s;
	fcd_sync_s r_reg, r_next;
	always_comb begin
		r_next = r_reg;
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
	assign q = r_reg.s2;
endmodule // fcd_sync
`default_nettype wire

// ==== hdl/fcd_top.sv ====
// flash command controller: wishbone registers to flash command sequences
// Operation
// R1: one write of F0 anywhere resets bank; erase-suspended bank returns to suspend-read.
// R2: host issues reset to leave identification, or when timeout flag rises during status.
// R3: array reads need no unlock or command cycles.
// R4: all command cycles are writes except plain reads and identification fourth cycle.
// R5: upper data byte is ignored in command cycles.
// R6: upper address bits are ignored unless a sector or bank is meant.
// R7: identification is 555/AA, 2AA/55, bank 555/90, then reads at X00, X01.
// R8: identification read at sector offset X02 gives 01h protected, 00h unprotected.
// R9: identification read at bank offset X03 gives 80h factory locked, else 00h.
// R10: program is 555/AA, 2AA/55, 555/A0, then target address with data.
// R11: address taken at later falling strobe edge, data at earlier rising edge.
// R12: bypass entered by three writes ending 20 at 555; then two-write program.
// R13: bypass left by 90 then 00 at any addresses.
// R14: erase is six writes; last is 10 at 555 or 30 at sector.
// R15: sector chosen uniquely by upper address field for erase and protect queries.
// R16: suspend is B0 at bank address, honoured only during sector erase.
// R17: while suspended, other sectors read and program, and identification is accepted.
// R18: resume is 30 at suspended bank, accepted only while suspended.
// R19: query is 98 at 55, only in array read or identification mode.
// R20: secure entry is three writes ending 88; exit four writes ending 00.
// R21: busy device shows poll, toggle, window and timeout bits and ready-busy pin.
// R22: further sector addresses with 30 accepted within 50 us window.
// R23: suspend takes effect within 20 us, immediately inside the erase window.
// R24: in bypass only bypass program and bypass exit are accepted; op_ok also accepts read and poll orders there.
// R25: a write off the expected sequence abandons it and returns to array reads.
`timescale 1ns/1ps
`default_nettype none
`include "fcd_consts.svh"
module fcd_top #(
	parameter logic [15:0] WINDOW_CYC = 16'(`FCD_CYC_DN(`FCD_WINDOW_US * 1000)),
	parameter logic [15:0] SUSP_CYC = 16'(`FCD_CYC_UP(`FCD_SUSP_US * 1000))
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [19:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [15:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	input wire logic ready_busy_output
);
	fcd_pkg::fcd_main_s r_reg, r_next;
	fcd_cyc_if cyc ();
	logic [16:0] pins_sync;

	fcd_sync #(.W(17)) u_sync (
		.clock(clock),
		.srst(srst),
		.d({ready_busy_output, flash_dq_in}),
		.q(pins_sync)
	);
	fcd_cycle u_cycle (
		.clock(clock),
		.srst(srst),
		.cyc(cyc.eng),
		.dq_sync(pins_sync[15:0]),
		.flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe(flash_dq_oe),
		.flash_ce_n(flash_ce_n),
		.flash_we_n(flash_we_n),
		.flash_oe_n(flash_oe_n)
	);

	function automatic logic [2:0] seq_len(input fcd_pkg::fcd_op_e op);
		unique case (op)
			fcd_pkg::OP_BYP_PROG, fcd_pkg::OP_BYP_EXIT: seq_len = 3'h2;
			fcd_pkg::OP_BYP_EN, fcd_pkg::OP_SEC_EN: seq_len = 3'h3;
			fcd_pkg::OP_IDENT, fcd_pkg::OP_PROG, fcd_pkg::OP_SEC_EX: seq_len = 3'h4;
			fcd_pkg::OP_CHIP, fcd_pkg::OP_SECT: seq_len = 3'h6;
			default: seq_len = 3'h1;
		endcase
	endfunction

	function automatic logic [36:0] wcmd(input logic [19:0] a, input logic [7:0] c);
		wcmd = {1'b0, a, 8'h00, c}; // R5
	endfunction

	// entry is {read, address, data}; unlock cycles keep the caller's upper bits
	function automatic logic [36:0] seq_ent(input fcd_pkg::fcd_op_e op,
		input logic [2:0] step, input logic [19:0] a, input logic [15:0] d);
		logic [19:0] u1;
		logic [19:0] u2;
		logic [7:0] c3;
		u1 = {a[19:11], `FCD_ADR_UNLOCK1}; // R6
		u2 = {a[19:11], `FCD_ADR_UNLOCK2};
		c3 = `FCD_CMD_ERASE;
		unique case (op)
			fcd_pkg::OP_IDENT: c3 = `FCD_CMD_IDENT;
			fcd_pkg::OP_SEC_EX: c3 = `FCD_CMD_IDENT;
			fcd_pkg::OP_PROG: c3 = `FCD_CMD_PROG;
			fcd_pkg::OP_BYP_EN: c3 = `FCD_CMD_BYPASS;
			fcd_pkg::OP_SEC_EN: c3 = `FCD_CMD_SECURE;
			default: c3 = `FCD_CMD_ERASE;
		endcase
		unique case (op)
			fcd_pkg::OP_RESET: seq_ent = wcmd(a, `FCD_CMD_RESET); // R1
			fcd_pkg::OP_READ, fcd_pkg::OP_POLL: seq_ent = {1'b1, a, 16'h0000}; // R3
			fcd_pkg::OP_BYP_PROG: seq_ent = (step == 3'h0) ? wcmd(a, `FCD_CMD_PROG) // R12
				: {1'b0, a, d};
			fcd_pkg::OP_BYP_EXIT: seq_ent = (step == 3'h0) ? wcmd(a, `FCD_CMD_IDENT) // R13
				: wcmd(a, `FCD_CMD_EXIT);
			fcd_pkg::OP_SECT_ADD, fcd_pkg::OP_RESUME: seq_ent = wcmd(a, `FCD_CMD_SECTOR); // R18
			fcd_pkg::OP_SUSPEND: seq_ent = wcmd(a, `FCD_CMD_SUSPEND); // R16
			fcd_pkg::OP_QUERY: seq_ent = wcmd({a[19:11], `FCD_ADR_QUERY}, `FCD_CMD_QUERY); // R19
			default: begin
				// unlock-prefixed sequences
				unique case (step)
					3'h0, 3'h3: seq_ent = wcmd(u1, `FCD_CMD_UNLOCK1);
					3'h1, 3'h4: seq_ent = wcmd(u2, `FCD_CMD_UNLOCK2);
					3'h2: seq_ent = wcmd(u1, c3); // R7 R10 R12 R20
					default: seq_ent = (op == fcd_pkg::OP_CHIP) ? wcmd(u1, `FCD_CMD_CHIP)
						: wcmd(a, `FCD_CMD_SECTOR); // R14 R15
				endcase
				if (step == 3'h3) begin
					if (op == fcd_pkg::OP_IDENT) begin
						seq_ent = {1'b1, a, 16'h0000}; // R4 R7 R8 R9
					end else if (op == fcd_pkg::OP_PROG) begin
						seq_ent = {1'b0, a, d}; // R10
					end else if (op == fcd_pkg::OP_SEC_EX) begin
						seq_ent = wcmd(a, `FCD_CMD_EXIT); // R20
					end
				end
			end
		endcase
	endfunction

	// which operations the device will take in the mode the host believes it is in
	function automatic logic op_ok(input fcd_pkg::fcd_main_s s, input fcd_pkg::fcd_op_e op);
		op_ok = 1'b1;
		if (s.byp) begin
			op_ok = op inside {fcd_pkg::OP_BYP_PROG, fcd_pkg::OP_BYP_EXIT, // R24
				fcd_pkg::OP_READ, fcd_pkg::OP_POLL};
		end else if (s.sect && !s.susp) begin
			op_ok = op inside {fcd_pkg::OP_SUSPEND, fcd_pkg::OP_SECT_ADD,
				fcd_pkg::OP_READ, fcd_pkg::OP_POLL};
		end
		unique case (op)
			fcd_pkg::OP_BYP_PROG, fcd_pkg::OP_BYP_EXIT: op_ok = op_ok && s.byp; // R12 R13
			fcd_pkg::OP_QUERY: op_ok = op_ok && !s.sect && !s.susp; // R19
			fcd_pkg::OP_SUSPEND: op_ok = op_ok && s.sect && !s.susp; // R16
			fcd_pkg::OP_RESUME: op_ok = op_ok && s.susp; // R18
			fcd_pkg::OP_SECT_ADD: op_ok = op_ok && s.sect && (s.win_cnt != 16'h0000); // R22
			fcd_pkg::OP_CHIP, fcd_pkg::OP_SECT: op_ok = op_ok && !s.susp;
			default: op_ok = op_ok; // R17
		endcase
	endfunction

	function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] v,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			lanes[8*i +: 8] = s[i] ? v[8*i +: 8] : o[8*i +: 8];
		end
	endfunction

	always_comb begin
		logic [36:0] e;
		logic fin;
		logic [31:0] sw;
		fcd_pkg::fcd_op_e nop;
		e = seq_ent(r_reg.op, r_reg.step, r_reg.addr, r_reg.wdata);
		fin = 1'b0;
		sw = 32'h0000_0000;
		nop = fcd_pkg::fcd_op_e'(wb_dat_i[3:0]);
		r_next = r_reg;
		r_next.req = 1'b0;
		r_next.ack = 1'b0;
		if (r_reg.win_cnt != 16'h0000) begin
			r_next.win_cnt = r_reg.win_cnt - 16'h0001; // R22
		end
		unique case (r_reg.st)
			fcd_pkg::ST_IDLE: begin
			end
			fcd_pkg::ST_ISSUE: begin
				r_next.req = 1'b1;
				r_next.req_wr = !e[36];
				r_next.req_addr = e[35:16];
				r_next.req_data = e[15:0];
				r_next.st = fcd_pkg::ST_WAIT;
			end
			fcd_pkg::ST_WAIT: if (cyc.done) begin
				if (e[36]) begin
					r_next.rdata = cyc.rdata;
				end
				if (r_reg.op == fcd_pkg::OP_POLL) begin
					// two reads in a row: toggle stopped means finished
					r_next.prev = cyc.rdata;
					r_next.phase = 1'b1;
					r_next.st = fcd_pkg::ST_ISSUE;
					if (r_reg.phase && cyc.rdata[`FCD_DQ_TOGGLE1] == r_reg.prev[`FCD_DQ_TOGGLE1]) begin
						r_next.st = fcd_pkg::ST_IDLE; // R21
						r_next.busy = 1'b0;
						r_next.done = 1'b1;
						r_next.sect = r_reg.sect && r_reg.susp;
					end else if (r_reg.phase && cyc.rdata[`FCD_DQ_TIMEOUT]) begin
						r_next.tmo_seen = 1'b1; // R2
						r_next.poll_fail = 1'b1;
						r_next.op = fcd_pkg::OP_RESET;
						r_next.step = 3'h0;
					end
				end else if (r_reg.step == seq_len(r_reg.op) - 3'h1) begin
					fin = 1'b1;
				end else begin
					r_next.step = r_reg.step + 3'h1;
					r_next.st = fcd_pkg::ST_ISSUE;
				end
			end
			fcd_pkg::ST_SUSP: begin
				r_next.wait_cnt = r_reg.wait_cnt - 16'h0001;
				if (r_reg.wait_cnt == 16'h0000) begin
					r_next.st = fcd_pkg::ST_IDLE; // R23
					r_next.busy = 1'b0;
					r_next.done = 1'b1;
					r_next.wait_cnt = 16'h0000;
				end
			end
		endcase
		if (fin) begin
			r_next.st = fcd_pkg::ST_IDLE;
			r_next.busy = 1'b0;
			r_next.done = 1'b1;
			unique case (r_reg.op)
				fcd_pkg::OP_RESET: begin
					r_next.ident = 1'b0; // R1 R2
					r_next.sect = r_reg.sect && r_reg.susp;
				end
				fcd_pkg::OP_IDENT: r_next.ident = 1'b1;
				fcd_pkg::OP_BYP_EN: r_next.byp = 1'b1; // R12
				fcd_pkg::OP_BYP_EXIT: r_next.byp = 1'b0; // R13
				fcd_pkg::OP_SEC_EN: r_next.secure = 1'b1; // R20
				fcd_pkg::OP_SEC_EX: r_next.secure = 1'b0;
				fcd_pkg::OP_RESUME: r_next.susp = 1'b0;
				fcd_pkg::OP_SECT, fcd_pkg::OP_SECT_ADD: begin
					r_next.sect = 1'b1;
					r_next.win_cnt = WINDOW_CYC; // R22
				end
				fcd_pkg::OP_SUSPEND: begin
					r_next.susp = 1'b1;
					r_next.win_cnt = 16'h0000;
					// inside the window the device stops at once, so no wait
					if (r_reg.win_cnt == 16'h0000) begin
						r_next.st = fcd_pkg::ST_SUSP; // R23
						r_next.wait_cnt = SUSP_CYC;
						r_next.busy = 1'b1;
						r_next.done = 1'b0;
					end
				end
				fcd_pkg::OP_PROG, fcd_pkg::OP_BYP_PROG, fcd_pkg::OP_CHIP: begin
					r_next.op = fcd_pkg::OP_POLL; // R21
					r_next.step = 3'h0;
					r_next.phase = 1'b0;
					r_next.st = fcd_pkg::ST_ISSUE;
					r_next.busy = 1'b1;
					r_next.done = 1'b0;
				end
				default: begin
				end
			endcase
		end
		sw[`FCD_ST_BUSY] = r_reg.busy;
		sw[`FCD_ST_DONE] = r_reg.done;
		sw[`FCD_ST_REFUSED] = r_reg.refused;
		sw[`FCD_ST_READY] = pins_sync[16]; // R21
		sw[`FCD_ST_TIMEOUT] = r_reg.tmo_seen;
		sw[`FCD_ST_BYPASS] = r_reg.byp;
		sw[`FCD_ST_IDENT] = r_reg.ident;
		sw[`FCD_ST_SUSP] = r_reg.susp;
		sw[`FCD_ST_SECT] = r_reg.sect;
		sw[`FCD_ST_SECURE] = r_reg.secure;
		sw[`FCD_ST_FAIL] = r_reg.poll_fail;
		if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
			r_next.ack = 1'b1;
			r_next.dat = 32'h0000_0000;
			if (wb_we_i) begin
				unique case (wb_adr_i)
					`FCD_REG_CTRL: if (wb_sel_i[0]) begin
						// a refused order never reaches the pins
						if (r_reg.busy || !op_ok(r_reg, nop)) begin
							r_next.refused = 1'b1;
						end else begin
							r_next.refused = 1'b0;
							r_next.done = 1'b0;
							r_next.poll_fail = 1'b0;
							r_next.busy = 1'b1;
							r_next.op = nop;
							r_next.step = 3'h0;
							r_next.phase = 1'b0;
							r_next.st = fcd_pkg::ST_ISSUE;
						end
					end
					`FCD_REG_ADDR: r_next.addr = 20'(lanes(32'(r_reg.addr), wb_dat_i, wb_sel_i));
					`FCD_REG_WDATA: r_next.wdata = 16'(lanes(32'(r_reg.wdata), wb_dat_i, wb_sel_i));
					default: begin
					end
				endcase
			end else begin
				unique case (wb_adr_i)
					`FCD_REG_CTRL: r_next.dat = 32'(r_reg.op);
					`FCD_REG_ADDR: r_next.dat = 32'(r_reg.addr);
					`FCD_REG_WDATA: r_next.dat = 32'(r_reg.wdata);
					`FCD_REG_STATUS: r_next.dat = sw;
					`FCD_REG_RDATA: r_next.dat = 32'(r_reg.rdata);
					default: r_next.dat = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
	assign cyc.req = r_reg.req;
	assign cyc.wr = r_reg.req_wr;
	assign cyc.addr = r_reg.req_addr;
	assign cyc.wdata = r_reg.req_data;
	assign wb_ack_o = r_reg.ack;
	assign wb_dat_o = r_reg.dat;

	default clocking dc @(posedge clock);
	endclocking
	default disable iff (srst);
	logic issuing;
	assign issuing = r_reg.st == fcd_pkg::ST_ISSUE;
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_query_mode: assert property ( // R19
		issuing && r_reg.op == fcd_pkg::OP_QUERY |-> !r_reg.sect && !r_reg.susp && !r_reg.byp)
		else $error("query outside array or identification mode");
	a_bypass_prog_gate: assert property ( // R12
		issuing && r_reg.op == fcd_pkg::OP_BYP_PROG |-> r_reg.byp)
		else $error("short program without bypass");
	a_bypass_only: assert property (issuing && r_reg.byp |-> // R24
		r_reg.op inside {fcd_pkg::OP_BYP_PROG, fcd_pkg::OP_BYP_EXIT, fcd_pkg::OP_READ,
		fcd_pkg::OP_POLL})
		else $error("illegal command in bypass");
	a_suspend_gate: assert property ( // R16
		issuing && r_reg.op == fcd_pkg::OP_SUSPEND |-> r_reg.sect && !r_reg.susp)
		else $error("suspend outside sector erase");
	a_resume_gate: assert property ( // R18
		issuing && r_reg.op == fcd_pkg::OP_RESUME |-> r_reg.susp)
		else $error("resume while not suspended");
	a_reset_result: assert property (r_reg.st == fcd_pkg::ST_WAIT && // R1
		r_reg.op == fcd_pkg::OP_RESET && cyc.done |=> !r_reg.ident && $stable(r_reg.susp))
		else $error("reset left wrong mode");
	a_cmd_upper_zero: assert property (r_reg.req && r_reg.req_wr && // R5
		!((r_reg.op inside {fcd_pkg::OP_PROG, fcd_pkg::OP_BYP_PROG}) &&
		r_reg.step == seq_len(r_reg.op) - 3'h1) |-> r_reg.req_data[15:8] == 8'h00)
		else $error("command cycle with upper byte set");
	a_read_cycles: assert property (r_reg.req && !r_reg.req_wr |-> // R4
		r_reg.op inside {fcd_pkg::OP_READ, fcd_pkg::OP_POLL} ||
		(r_reg.op == fcd_pkg::OP_IDENT && r_reg.step == 3'h3))
		else $error("read inside a command sequence");
	a_window_open: assert property ( // R22
		issuing && r_reg.op == fcd_pkg::OP_SECT_ADD |-> r_reg.win_cnt != 16'h0000)
		else $error("sector added after window");
	a_timeout_reset: assert property (r_reg.st == fcd_pkg::ST_WAIT && // R2
		r_reg.op == fcd_pkg::OP_POLL && r_reg.phase && cyc.done &&
		cyc.rdata[`FCD_DQ_TIMEOUT] && cyc.rdata[`FCD_DQ_TOGGLE1] != r_reg.prev[`FCD_DQ_TOGGLE1]
		|=> issuing && r_reg.op == fcd_pkg::OP_RESET ##1 r_reg.req && r_reg.req_wr)
		else $error("no reset after timeout");
	c_program_poll: cover property (r_reg.op == fcd_pkg::OP_POLL && $rose(r_reg.done));
	c_suspend_wait: cover property (r_reg.st == fcd_pkg::ST_SUSP ##1 r_reg.st == fcd_pkg::ST_IDLE);
	c_bypass_prog: cover property (issuing && r_reg.op == fcd_pkg::OP_BYP_PROG);
endmodule // fcd_top
`default_nettype wire

// ==== verif/fcd_flash_model.sv ====
// behavioural flash device answering command cycles on the pins
`timescale 1ns/1ps
`default_nettype none
module fcd_flash_model #(
	parameter logic [15:0] MAKER = 16'h00C3, // arbitrary value
	parameter logic [15:0] PART = 16'h005A // arbitrary value
) (
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [19:0] addr,
	input wire logic [15:0] dq_host,
	output logic [15:0] dq_dev,
	output logic rdy
);
	logic [15:0] mem [0:255];
	logic [15:0] q = 16'h0000;
	logic [19:0] la = 20'h00000;
	int st = 0;
	int busy = 0;
	logic ident = 0;
	logic byp = 0;
	logic prog = 0;
	logic tog = 0;
	wire wr_n = we_n | ce_n;
	wire rd_n = oe_n | ce_n;
	// released pins show the inverse, so a stale value never passes
	assign dq_dev = rd_n ? ~q : q;
	assign rdy = busy == 0;
	always @(negedge wr_n) la = addr;
	always @(posedge wr_n) begin
		if (prog) begin
			mem[la[7:0]] = dq_host;
			prog = 0;
			busy = 3;
		end else if (dq_host[7:0] == 8'hF0) begin
			st = 0;
			ident = 0;
		end else if (byp && st == 0 && dq_host[7:0] == 8'hA0) prog = 1;
		else if (byp && dq_host[7:0] == 8'h90) st = 5;
		else if (byp && st == 5 && dq_host[7:0] == 8'h00) byp = 0;
		else if (byp) st = 0;
		else if (st == 0 && la[10:0] == 11'h555 && dq_host[7:0] == 8'hAA) st = 1;
		else if (st == 1 && la[10:0] == 11'h2AA && dq_host[7:0] == 8'h55) st = 2;
		else if (st == 2 && la[10:0] == 11'h555) begin
			ident = dq_host[7:0] == 8'h90;
			byp = dq_host[7:0] == 8'h20;
			prog = dq_host[7:0] == 8'hA0;
			st = 0;
		end else st = 0;
	end
	always @(negedge rd_n) begin
		if (busy > 0) begin
			busy--;
			tog = ~tog;
			q = {9'h000, tog, 6'h00};
		end else if (ident) q = addr[1:0] == 2'h0 ? MAKER : addr[1:0] == 2'h1 ? PART :
			addr[1:0] == 2'h3 ? 16'h0080 : 16'h0000;
		else q = mem[addr[7:0]];
	end
endmodule // fcd_flash_model
`default_nettype wire

// ==== verif/test_fcd_top.sv ====
// self-checking bench of the flash command controller with a device model
`timescale 1ns/1ps
`default_nettype none
`include "fcd_consts.svh"
module test_fcd_top;
	localparam logic [15:0] MAKER = 16'h00C3; // arbitrary value
	localparam logic [15:0] PART = 16'h005A; // arbitrary value
	logic clock = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic [3:0] wb_sel_i = 4'hF;
	logic [19:0] fa;
	logic [15:0] fdo, fdi;
	logic foe, ce_n, we_n, oe_n, rdy;
	int n_fail = 0;
	int num_checks = 0;
	wire [15:0] dq = foe ? fdo : fdi;
	always #2 clock = ~clock;
	fcd_top #(.WINDOW_CYC(16'h00C8), .SUSP_CYC(16'h0032)) u_dut (.clock(clock), .srst(srst),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.flash_addr(fa), .flash_dq_out(fdo), .flash_dq_oe(foe), .flash_dq_in(dq),
		.flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .ready_busy_output(rdy));
	fcd_flash_model #(.MAKER(MAKER), .PART(PART)) u_mem (.ce_n(ce_n), .we_n(we_n),
		.oe_n(oe_n), .addr(fa), .dq_host(dq), .dq_dev(fdi), .rdy(rdy));
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle; the request stands until ack is seen high
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++)
			@(posedge clock);
		if (n >= 50) begin
			n_fail++;
			finish_test;
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clock);
	endtask
	task automatic op(input logic [3:0] code, input logic [19:0] a, input logic [15:0] d);
		int n;
		wb(1'b1, `FCD_REG_ADDR, {12'h000, a});
		wb(1'b1, `FCD_REG_WDATA, {16'h0000, d});
		wb(1'b1, `FCD_REG_CTRL, {28'h0, code});
		for (n = 0; n < 400; n++) begin
			wb(1'b0, `FCD_REG_STATUS, 32'h0);
			if (q[`FCD_ST_BUSY] === 1'b0) break;
		end
		if (n >= 400) begin
			n_fail++;
			finish_test;
		end
	endtask
	task automatic st_chk(input int b, input logic e);
		wb(1'b0, `FCD_REG_STATUS, 32'h0);
		chk({31'h0, q[b]}, {31'h0, e});
	endtask
	task automatic rd_chk(input logic [19:0] a, input logic [15:0] e);
		op(4'h1, a, 16'h0000);
		wb(1'b0, `FCD_REG_RDATA, 32'h0);
		chk(q, {16'h0000, e});
	endtask
	task automatic t_regs;
		wb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		st_chk(`FCD_ST_BUSY, 1'b0);
	endtask
	task automatic t_prog;
		op(4'h3, 20'h00010, 16'hA5C3);
		st_chk(`FCD_ST_DONE, 1'b1);
		rd_chk(20'h00010, 16'hA5C3);
	endtask
	task automatic t_ident;
		op(4'h2, 20'h00000, 16'h0000);
		wb(1'b0, `FCD_REG_RDATA, 32'h0);
		chk(q, {16'h0000, MAKER});
		st_chk(`FCD_ST_IDENT, 1'b1);
		rd_chk(20'h00001, PART);
		rd_chk(20'h00003, 16'h0080);
		rd_chk(20'h01002, 16'h0000);
		op(4'h0, 20'h00000, 16'h0000);
		rd_chk(20'h00010, 16'hA5C3);
	endtask
	// a normal program inside bypass must be refused and leave the pins alone
	task automatic t_byp;
		op(4'h4, 20'h00000, 16'h0000);
		st_chk(`FCD_ST_BYPASS, 1'b1);
		op(4'h3, 20'h00030, 16'h0F0F);
		st_chk(`FCD_ST_REFUSED, 1'b1);
		op(4'h5, 20'h00020, 16'h0F0F);
		op(4'h6, 20'h00000, 16'h0000);
		st_chk(`FCD_ST_BYPASS, 1'b0);
		rd_chk(20'h00020, 16'h0F0F);
		op(4'h5, 20'h00020, 16'h0F0F);
		st_chk(`FCD_ST_REFUSED, 1'b1);
	endtask
	// erase family: refusals, chip erase, sector erase with suspend inside the window
	task automatic t_erase;
		op(4'hA, 20'h00010, 16'h0000);
		st_chk(`FCD_ST_REFUSED, 1'b1);
		op(4'hB, 20'h00010, 16'h0000);
		st_chk(`FCD_ST_REFUSED, 1'b1);
		op(4'hC, 20'h00000, 16'h0000);
		st_chk(`FCD_ST_REFUSED, 1'b0);
		op(4'h7, 20'h00010, 16'h0000);
		st_chk(`FCD_ST_DONE, 1'b1);
		op(4'h8, 20'h00010, 16'h0000);
		st_chk(`FCD_ST_SECT, 1'b1);
		op(4'hA, 20'h00010, 16'h0000);
		st_chk(`FCD_ST_SUSP, 1'b1);
		rd_chk(20'h00010, 16'hA5C3);
		op(4'hB, 20'h00010, 16'h0000);
		st_chk(`FCD_ST_SUSP, 1'b0);
		op(4'hF, 20'h00010, 16'h0000);
		st_chk(`FCD_ST_SECT, 1'b0);
	endtask
	initial begin
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		t_regs;
		t_prog;
		t_ident;
		t_byp;
		t_erase;
		finish_test;
	end
	initial begin
		#200000;
		n_fail++;
		finish_test;
	end
endmodule // test_fcd_top
`default_nettype wire
